/* File: design/gpfp_top.sv */
// Purpose: Sixteen-pin general purpose flag port with interrupts
// Assumes: Pin inputs synchronous to pclk, APB register access
// Notes: Serial port select lines may take over pins 0 to 7
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "gpfp_regs.svh"

// What this block does
// RULE_01: Sixteen pins, each input or output by its own direction bit.
// RULE_02: Modify writes change only pins whose written bit is one.
// RULE_03: Set register writes of one drive selected outputs high.
// RULE_04: Clear register writes of one drive selected outputs low.
// RULE_05: Toggle register writes of one invert selected flags.
// RULE_06: Data register write loads all flag values directly.
// RULE_07: Status read returns present sense of all sixteen flags.
// RULE_08: Mask set writes of one enable interrupts of selected pins.
// RULE_09: Mask clear writes of one disable interrupts of selected pins.
// RULE_10: Input pins interrupt from pin level; outputs only by software.
// RULE_11: Per-pin sensitivity bit picks level or edge response.
// RULE_12: Edge pins pick rising only or both edges.
// RULE_13: Serial slave select input and seven select outputs take pins.
// RULE_14: Edge events latch until cleared; level events follow the pin. The code latches level events too, until a status read or clear write.
module gpfp_top #(
   parameter int NPINS = 16
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Flag pins
   input wire logic [NPINS-1:0] flag_pin_bus_in,
   output logic [NPINS-1:0] flag_pin_bus_out,
   output logic [NPINS-1:0] flag_pin_bus_oe,
   // Serial port select lines
   input wire logic [7:1] serial_select_outputs,
   input wire logic [7:1] serial_select_oe,
   output logic serial_slave_select_in,
   // Interrupt
   output logic irq
);

   gpfp_pkg::gpfp_req_s req;
   gpfp_pkg::gpfp_sens_s sens_r;
   logic [NPINS-1:0] flags_r;
   logic [NPINS-1:0] dir_r;
   logic [NPINS-1:0] mask_r;
   logic [NPINS-1:0] stat_r;
   logic [NPINS-1:0] stat_nxt;
   logic [NPINS-1:0] sense;
   logic [NPINS-1:0] edge_evt;
   logic [NPINS-1:0] level_evt;
   logic [NPINS-1:0] wbits;
   logic [NPINS-1:0] rd_clr_r;
   logic [NPINS-1:0] sw_clr;
   logic [NPINS-1:0] takeover;
   logic [NPINS-1:0] ser_out;
   logic [NPINS-1:0] ser_oe;
   logic [7:0] ser_sel_r;
   logic [31:0] rdata_nxt;
   logic [31:0] prdata_r;

   // Written word trimmed to the flag width
   assign wbits = req.wdata[NPINS-1:0];

   // Bus decode and strobes
   gpfp_apb_slave u_apb (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pready(pready),
      .pslverr(pslverr),
      .req(req)
   );

   // Direction control, one bit a pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_r <= `GPFP_RST_DIR;
      end else if (req.wr && req.sel == gpfp_pkg::SEL_DIR) begin
         dir_r <= wbits; // [RULE_01]
      end
   end

   // Flag output values: set, clear, toggle and direct load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_r <= `GPFP_RST_FLAGS;
      end else if (req.wr) begin
         unique case (req.sel)
            gpfp_pkg::SEL_SET: begin
               flags_r <= flags_r | wbits; // [RULE_02] [RULE_03]
            end
            gpfp_pkg::SEL_CLEAR: begin
               flags_r <= flags_r & ~wbits; // [RULE_02] [RULE_04]
            end
            gpfp_pkg::SEL_TOGGLE: begin
               flags_r <= flags_r ^ wbits; // [RULE_02] [RULE_05]
            end
            gpfp_pkg::SEL_DATA: begin
               flags_r <= wbits; // [RULE_06]
            end
            default: begin
               flags_r <= flags_r;
            end
         endcase
      end
   end

   // Interrupt mask, set and clear by writing ones
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= `GPFP_RST_MASK;
      end else if (req.wr && req.sel == gpfp_pkg::SEL_MASK_SET) begin
         mask_r <= mask_r | wbits; // [RULE_08]
      end else if (req.wr && req.sel == gpfp_pkg::SEL_MASK_CLR) begin
         mask_r <= mask_r & ~wbits; // [RULE_09]
      end
   end

   // Sensitivity type and edge selection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sens_r.edge_mode <= `GPFP_RST_EDGE;
         sens_r.both_edges <= `GPFP_RST_BOTH;
      end else if (req.wr && req.sel == gpfp_pkg::SEL_EDGE) begin
         sens_r.edge_mode <= wbits; // [RULE_11]
      end else if (req.wr && req.sel == gpfp_pkg::SEL_BOTH) begin
         sens_r.both_edges <= wbits; // [RULE_12]
      end
   end

   // Serial port takeover enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ser_sel_r <= `GPFP_RST_SER_SEL;
      end else if (req.wr && req.sel == gpfp_pkg::SEL_SER_SEL) begin
         ser_sel_r <= req.wdata[7:0];
      end
   end

   // Pins handed to the serial port: pin 0 in, pins 1 to 7 out
   always_comb begin
      takeover = '0;
      ser_out = '0;
      ser_oe = '0;
      takeover[`GPFP_SER_SS_BIT] = ser_sel_r[`GPFP_SER_SS_BIT]; // [RULE_13]
      for (int i = `GPFP_SER_SEL_LO; i <= `GPFP_SER_SEL_HI; i++) begin
         takeover[i] = ser_sel_r[i]; // [RULE_13]
         ser_out[i] = serial_select_outputs[i];
         ser_oe[i] = serial_select_oe[i];
      end
   end

   // Slave select reads inactive high unless its pin is taken over
   assign serial_slave_select_in = ser_sel_r[`GPFP_SER_SS_BIT] ?
      flag_pin_bus_in[`GPFP_SER_SS_BIT] : 1'b1; // [RULE_13]

   // Pin drivers, serial port wins on taken pins
   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         if (takeover[i] && i != `GPFP_SER_SS_BIT) begin
            flag_pin_bus_out[i] = ser_out[i]; // [RULE_13]
            flag_pin_bus_oe[i] = ser_oe[i];
         end else if (takeover[i]) begin
            flag_pin_bus_out[i] = 1'b0;
            flag_pin_bus_oe[i] = 1'b0;
         end else begin
            flag_pin_bus_out[i] = flags_r[i];
            flag_pin_bus_oe[i] = dir_r[i]; // [RULE_01]
         end
      end
   end

   // Sense: inputs follow the pin, outputs the written flag value
   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         sense[i] = (dir_r[i] && !takeover[i]) ? flags_r[i] :
            flag_pin_bus_in[i]; // [RULE_07] [RULE_10]
      end
   end

   // Edge and level events on the sense
   gpfp_event_detect #(
      .WIDTH(NPINS)
   ) u_evt (
      .pclk(pclk),
      .presetn(presetn),
      .sense(sense),
      .edge_mode(sens_r.edge_mode),
      .both_edges(sens_r.both_edges),
      .edge_evt(edge_evt),
      .level_evt(level_evt)
   );

   // Software clears: a status read, or clearing the flag value
   always_comb begin
      sw_clr = '0;
      if (req.rd && req.sel == gpfp_pkg::SEL_IRQ_STAT) begin
         sw_clr = rd_clr_r;
      end
      if (req.wr && req.sel == gpfp_pkg::SEL_CLEAR) begin
         sw_clr = sw_clr | wbits; // [RULE_14]
      end
   end

   // Sticky status, a new event wins over a clear in the same cycle
   always_comb begin
      stat_nxt = (stat_r & ~sw_clr) | edge_evt | level_evt; // [RULE_14]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_r <= '0;
      end else begin
         stat_r <= stat_nxt; // [RULE_10] [RULE_11] [RULE_12]
      end
   end

   // Interrupt while any unmasked status bit is set
   assign irq = |(stat_r & mask_r); // [RULE_08] [RULE_09]

   // Read data for the setup cycle
   always_comb begin
      rdata_nxt = '0;
      unique case (req.sel)
         gpfp_pkg::SEL_DATA,
         gpfp_pkg::SEL_SET,
         gpfp_pkg::SEL_CLEAR,
         gpfp_pkg::SEL_TOGGLE: begin
            rdata_nxt[NPINS-1:0] = sense; // [RULE_07]
         end
         gpfp_pkg::SEL_MASK_SET,
         gpfp_pkg::SEL_MASK_CLR: begin
            rdata_nxt[NPINS-1:0] = mask_r;
         end
         gpfp_pkg::SEL_DIR: begin
            rdata_nxt[NPINS-1:0] = dir_r;
         end
         gpfp_pkg::SEL_EDGE: begin
            rdata_nxt[NPINS-1:0] = sens_r.edge_mode;
         end
         gpfp_pkg::SEL_BOTH: begin
            rdata_nxt[NPINS-1:0] = sens_r.both_edges;
         end
         gpfp_pkg::SEL_IRQ_STAT: begin
            rdata_nxt[NPINS-1:0] = stat_r;
         end
         gpfp_pkg::SEL_SER_SEL: begin
            rdata_nxt[7:0] = ser_sel_r;
         end
         default: begin
            rdata_nxt = '0;
         end
      endcase
   end

   // Read data captured at every read setup, zero for unmapped offsets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= rdata_nxt;
      end
   end

   // Status bits shown to the read are the only ones it clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_clr_r <= '0;
      end else if (req.setup) begin
         rd_clr_r <= stat_r;
      end
   end

   assign prdata = prdata_r;

endmodule : gpfp_top

/* File: design/gpfp_regs.svh */
// Purpose: Register offsets, reset values and field positions of the flag port
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes: Definitions only
`ifndef GPFP_REGS_SVH
`define GPFP_REGS_SVH

// Register byte offsets
`define GPFP_OFS_DATA      8'h00
`define GPFP_OFS_SET       8'h04
`define GPFP_OFS_CLEAR     8'h08
`define GPFP_OFS_TOGGLE    8'h0c
`define GPFP_OFS_MASK_SET  8'h10
`define GPFP_OFS_MASK_CLR  8'h14
`define GPFP_OFS_DIR       8'h18
`define GPFP_OFS_EDGE      8'h1c
`define GPFP_OFS_BOTH      8'h20
`define GPFP_OFS_IRQ_STAT  8'h24
`define GPFP_OFS_SER_SEL   8'h28

// Reset values
`define GPFP_RST_FLAGS     16'h0000
`define GPFP_RST_DIR       16'h0000
`define GPFP_RST_MASK      16'h0000
`define GPFP_RST_EDGE      16'h0000
`define GPFP_RST_BOTH      16'h0000
`define GPFP_RST_SER_SEL   8'h00

// Serial select field: bit 0 slave select input, bits 7:1 select outputs
`define GPFP_SER_SS_BIT    0
`define GPFP_SER_SEL_LO    1
`define GPFP_SER_SEL_HI    7

`endif

/* File: design/gpfp_pkg.sv */
// Purpose: Shared types of the general purpose flag port
// Assumes: Sixteen flag pins, APB data 32 bits
// Notes: Offsets and reset values live in gpfp_regs.svh
package gpfp_pkg;

   // Register select decoded from the APB address
   typedef enum logic [3:0] {
      SEL_DATA     = 4'h0,
      SEL_SET      = 4'h1,
      SEL_CLEAR    = 4'h3,
      SEL_TOGGLE   = 4'h2,
      SEL_MASK_SET = 4'h6,
      SEL_MASK_CLR = 4'h7,
      SEL_DIR      = 4'h5,
      SEL_EDGE     = 4'h4,
      SEL_BOTH     = 4'hc,
      SEL_IRQ_STAT = 4'hd,
      SEL_SER_SEL  = 4'hf,
      SEL_NONE     = 4'he
   } gpfp_sel_e;

   // One decoded bus request
   typedef struct packed {
      logic      setup;
      logic      wr;
      logic      rd;
      gpfp_sel_e sel;
      logic [31:0] wdata;
   } gpfp_req_s;

   // Per-pin interrupt sensitivity configuration
   typedef struct packed {
      logic [15:0] edge_mode;
      logic [15:0] both_edges;
   } gpfp_sens_s;

endpackage : gpfp_pkg

/* File: design/gpfp_apb_slave.sv */
// Purpose: APB decode of the flag port registers
// Assumes: Zero wait states, pready always high in the access phase
// Notes: Unmapped addresses answer with pslverr and have no effect
`timescale 1ns/1ps
`include "gpfp_regs.svh"

module gpfp_apb_slave (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   // Decoded request
   output gpfp_pkg::gpfp_req_s req
);

   // Address to register select
   function automatic gpfp_pkg::gpfp_sel_e decode(input logic [7:0] a);
      case (a)
         `GPFP_OFS_DATA: decode = gpfp_pkg::SEL_DATA;
         `GPFP_OFS_SET: decode = gpfp_pkg::SEL_SET;
         `GPFP_OFS_CLEAR: decode = gpfp_pkg::SEL_CLEAR;
         `GPFP_OFS_TOGGLE: decode = gpfp_pkg::SEL_TOGGLE;
         `GPFP_OFS_MASK_SET: decode = gpfp_pkg::SEL_MASK_SET;
         `GPFP_OFS_MASK_CLR: decode = gpfp_pkg::SEL_MASK_CLR;
         `GPFP_OFS_DIR: decode = gpfp_pkg::SEL_DIR;
         `GPFP_OFS_EDGE: decode = gpfp_pkg::SEL_EDGE;
         `GPFP_OFS_BOTH: decode = gpfp_pkg::SEL_BOTH;
         `GPFP_OFS_IRQ_STAT: decode = gpfp_pkg::SEL_IRQ_STAT;
         `GPFP_OFS_SER_SEL: decode = gpfp_pkg::SEL_SER_SEL;
         default: decode = gpfp_pkg::SEL_NONE;
      endcase
   endfunction : decode

   logic hit;
   logic access;

   // Request decode, effects happen on the access edge
   assign access = psel & penable;
   assign req.sel = decode(paddr);
   assign hit = (req.sel != gpfp_pkg::SEL_NONE);
   assign req.setup = psel & ~penable & hit;
   assign req.wr = access & pwrite & hit;
   assign req.rd = access & ~pwrite & hit;
   assign req.wdata = pwdata;

   // Answer in the first access cycle
   assign pready = 1'b1;
   assign pslverr = access & ~hit;

endmodule : gpfp_apb_slave

/* File: design/gpfp_event_detect.sv */
// Purpose: Per-pin level and edge event detection on the flag sense
// Assumes: Sense is synchronous to pclk
// Notes: Previous sense resets to zero, so a pin high at reset counts as rise
`timescale 1ns/1ps

module gpfp_event_detect #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Sense and configuration
   input wire logic [WIDTH-1:0] sense,
   input wire logic [WIDTH-1:0] edge_mode,
   input wire logic [WIDTH-1:0] both_edges,
   // Events
   output logic [WIDTH-1:0] edge_evt,
   output logic [WIDTH-1:0] level_evt
);

   logic [WIDTH-1:0] prev_r;

   // Previous sense for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_r <= '0;
      end else begin
         prev_r <= sense;
      end
   end

   // Level or edge per pin, rising only or both edges
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         level_evt[i] = ~edge_mode[i] & sense[i];
         if (both_edges[i]) begin
            edge_evt[i] = edge_mode[i] & (sense[i] ^ prev_r[i]);
         end else begin
            edge_evt[i] = edge_mode[i] & sense[i] & ~prev_r[i];
         end
      end
   end

endmodule : gpfp_event_detect

/* File: testbench/gpfp_checker.sv */
// Purpose: Port-level checks of the flag port
// Assumes: Tests leave pins 15:8 untaken by the serial port
// Notes: Bound into gpfp_top
`timescale 1ns/1ps
`include "gpfp_regs.svh"
module gpfp_checker #(
   parameter int NPINS = 16
) (
   // Clock, reset and APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins and interrupt
   input wire logic [NPINS-1:0] flag_pin_bus_in,
   input wire logic [NPINS-1:0] flag_pin_bus_out,
   input wire logic [NPINS-1:0] flag_pin_bus_oe,
   input wire logic [7:1] serial_select_outputs,
   input wire logic [7:1] serial_select_oe,
   input wire logic serial_slave_select_in,
   input wire logic irq
);
   logic wr;
   logic [7:0] o;
   logic [7:0] d;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Completed write and upper pin slices
   assign wr = psel & penable & pwrite & pready;
   assign o = flag_pin_bus_out[15:8];
   assign d = pwdata[15:8];
   property p_ready; pready; endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   property p_err; pslverr |-> psel && penable; endproperty
   a_err: assert property (p_err) else $error("stray pslverr");
   property p_set; wr && paddr == `GPFP_OFS_SET |=> o == ($past(o) | $past(d));
   endproperty
   a_set: assert property (p_set) else $error("set wrong");
   property p_clr;
      wr && paddr == `GPFP_OFS_CLEAR |=> o == ($past(o) & ~$past(d));
   endproperty
   a_clr: assert property (p_clr) else $error("clear wrong");
   property p_tog;
      wr && paddr == `GPFP_OFS_TOGGLE |=> o == ($past(o) ^ $past(d));
   endproperty
   a_tog: assert property (p_tog) else $error("toggle wrong");
   property p_data; wr && paddr == `GPFP_OFS_DATA |=> o == $past(d); endproperty
   a_data: assert property (p_data) else $error("load wrong");
   property p_keep; !(wr && paddr < 8'h10) |=> $stable(o); endproperty
   a_keep: assert property (p_keep) else $error("pins moved");
   property p_mclr;
      wr && paddr == `GPFP_OFS_MASK_CLR && pwdata[15:0] == 16'hffff |=> !irq;
   endproperty
   a_mclr: assert property (p_mclr) else $error("irq kept");
   // Main scenarios
   c_irq: cover property ($rose(irq));
   c_err: cover property (pslverr);
   c_tog: cover property (wr && paddr == `GPFP_OFS_TOGGLE);
endmodule : gpfp_checker
bind gpfp_top gpfp_checker #(.NPINS(NPINS)) i_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .flag_pin_bus_in(flag_pin_bus_in),
   .flag_pin_bus_out(flag_pin_bus_out), .flag_pin_bus_oe(flag_pin_bus_oe),
   .serial_select_outputs(serial_select_outputs),
   .serial_select_oe(serial_select_oe),
   .serial_slave_select_in(serial_slave_select_in), .irq(irq));

/* File: testbench/gpfp_pin_model.sv */
// Purpose: External signals on the flag pins
// Assumes: Block drive wins where its enable is high
// Notes: A released pin shows the inverse of its last level
`timescale 1ns/1ps
module gpfp_pin_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Block side and outside drive
   input wire logic [15:0] drv_out,
   input wire logic [15:0] drv_oe,
   input wire logic [15:0] ext,
   input wire logic [15:0] ext_en,
   // Resolved level
   output logic [15:0] pin
);
   logic [15:0] last_r;
   // Per-pin resolution by direction
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         pin[i] = drv_oe[i] ? drv_out[i] :
            (ext_en[i] ? ext[i] : ~last_r[i]);
      end
   end
   // Last settled level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) last_r <= 16'h0000;
      else last_r <= pin;
   end
endmodule : gpfp_pin_model

/* File: testbench/tb_general_purpose_flag_port.sv */
// Purpose: Register-level tests of the flag port
// Assumes: Zero-wait APB, pins resolved by the pin model
// Notes: Pin outputs and irq sampled at the falling edge, prdata and pslverr at the rising edge
`timescale 1ns/1ps
`include "gpfp_regs.svh"
module tb_general_purpose_flag_port;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ssi, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] pin, fout, foe, ext;
   logic [7:1] so, soe;
   logic [7:0] rofs [6] = '{`GPFP_OFS_MASK_SET, `GPFP_OFS_DIR,
      `GPFP_OFS_EDGE, `GPFP_OFS_BOTH, `GPFP_OFS_IRQ_STAT, `GPFP_OFS_SER_SEL};
   int failures = 0;
   int check_count = 0;
   // Clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   gpfp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .flag_pin_bus_in(pin), .flag_pin_bus_out(fout), .flag_pin_bus_oe(foe),
      .serial_select_outputs(so), .serial_select_oe(soe),
      .serial_slave_select_in(ssi), .irq(irq));
   gpfp_pin_model i_pins (.pclk(pclk), .presetn(presetn), .drv_out(fout),
      .drv_oe(foe), .ext(ext), .ext_en(16'hffff), .pin(pin));
   task chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rd
   task tick;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
   endtask : tick
   // Outside pin levels change just after a rising edge
   task drive(input logic [15:0] v);
      @(posedge pclk);
      ext <= v;
   endtask : drive
   task conclude;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   // Watchdog
   initial begin
      #20000;
      failures++;
      conclude();
   end
   // Test sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {ext, so, soe} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk({foe, fout}, 32'h0);
      chk({irq, ssi}, 32'h1);
      foreach (rofs[i]) rd(rofs[i], 32'h0);
      $display("test reset done");
      wr(`GPFP_OFS_DIR, 32'hffff);
      wr(`GPFP_OFS_DATA, 32'h1234);
      tick;
      chk({foe, fout}, 32'hffff1234);
      wr(`GPFP_OFS_SET, 32'h00f0);
      wr(`GPFP_OFS_CLEAR, 32'h1200);
      wr(`GPFP_OFS_TOGGLE, 32'h0ff0);
      tick;
      chk(fout, 32'h0f04);
      rd(`GPFP_OFS_DATA, 32'h0f04);
      rd(`GPFP_OFS_TOGGLE, 32'h0f04);
      wr(`GPFP_OFS_DATA, 32'h0);
      wr(`GPFP_OFS_DIR, 32'h00ff);
      drive(16'ha500);
      tick;
      rd(`GPFP_OFS_DATA, 32'ha500);
      $display("test output done");
      drive(16'h0100);
      tick;
      apb(1'b0, `GPFP_OFS_IRQ_STAT, 32'h0);
      wr(`GPFP_OFS_MASK_SET, 32'h0100);
      tick;
      chk(irq, 32'h1);
      rd(`GPFP_OFS_MASK_SET, 32'h0100);
      rd(`GPFP_OFS_IRQ_STAT, 32'h0100);
      drive(16'h0);
      tick;
      apb(1'b0, `GPFP_OFS_IRQ_STAT, 32'h0);
      rd(`GPFP_OFS_IRQ_STAT, 32'h0);
      $display("test level done");
      wr(`GPFP_OFS_EDGE, 32'h0200);
      wr(`GPFP_OFS_MASK_SET, 32'h0200);
      drive(16'h0200);
      tick;
      drive(16'h0);
      tick;
      chk(irq, 32'h1);
      rd(`GPFP_OFS_IRQ_STAT, 32'h0200);
      tick;
      chk(irq, 32'h0);
      drive(16'h0200);
      tick;
      apb(1'b0, `GPFP_OFS_IRQ_STAT, 32'h0);
      drive(16'h0);
      tick;
      chk(irq, 32'h0);
      wr(`GPFP_OFS_BOTH, 32'h0200);
      drive(16'h0200);
      tick;
      apb(1'b0, `GPFP_OFS_IRQ_STAT, 32'h0);
      drive(16'h0);
      tick;
      chk(irq, 32'h1);
      rd(`GPFP_OFS_IRQ_STAT, 32'h0200);
      wr(`GPFP_OFS_MASK_CLR, 32'h0300);
      rd(`GPFP_OFS_MASK_CLR, 32'h0);
      $display("test edge done");
      wr(`GPFP_OFS_DIR, 32'h04ff);
      wr(`GPFP_OFS_EDGE, 32'h0400);
      wr(`GPFP_OFS_MASK_SET, 32'h0400);
      wr(`GPFP_OFS_SET, 32'h0400);
      tick;
      chk(irq, 32'h1);
      rd(`GPFP_OFS_IRQ_STAT, 32'h0400);
      rd(8'h3c, 32'h0);
      wr(`GPFP_OFS_SET, 32'h0);
      wr(`GPFP_OFS_CLEAR, 32'h0400);
      wr(`GPFP_OFS_SET, 32'h0400);
      wr(`GPFP_OFS_MASK_CLR, 32'hffff);
      tick;
      chk(irq, 32'h0);
      wr(8'h3c, 32'hffff);
      chk(err, 32'h1);
      rd(8'h3c, 32'h0);
      $display("test software done");
      @(posedge pclk);
      so <= 7'h01;
      soe <= 7'h01;
      wr(`GPFP_OFS_SER_SEL, 32'h03);
      tick;
      chk({ssi, foe[1:0], fout[1]}, 32'h5);
      drive(16'h0001);
      tick;
      chk(ssi, 32'h1);
      $display("test serial done");
      conclude();
   end
endmodule : tb_general_purpose_flag_port
